/* logic/sfm_monitor.sv */
// Receive line-overhead monitor: B2 tally, signal-fail detectors, defect
// state and event latch registers with interrupt.
// Assumes line-side inputs come from framer logic on sys_clk.
`timescale 1ns/1ns
module sfm_monitor (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    input wire logic frame_tick,
    input wire logic [7:0] b2_err_mask,
    input wire logic los_state,
    input wire logic sef_state,
    input wire logic lof_state,
    input wire logic rdi_state,
    input wire logic s1_unstable,
    input wire logic k1k2_unstable,
    input wire logic sd_state,
    input wire logic b1_err_pulse,
    input wire logic rei_err_pulse,
    output logic int_req_n,
    output logic sf_state,
    output logic [3:0] b2_err_incr,
    output logic [3:0] rei_l_value,
    output logic sd_enable,
    output logic descramble_disable,
    output logic frame_standard_select,
    output logic rei_err_type,
    output logic b1_err_type,
    output logic b2_per_frame
);
    logic [7:0] ctrl_reg;
    logic [7:0] evt_reg;
    logic [7:0] evt_next;
    logic [7:0] evt_en_reg;
    logic [7:0] evt_set;
    logic [7:0] evt_rd_clr;
    logic [7:0] evt_wr_clr;
    logic [15:0] bwin_reg;
    logic [15:0] iset_reg;
    logic [15:0] iclr_reg;
    logic [15:0] bthr_reg;
    logic [7:0] rd_data_next;
    logic [7:0] stat_val;
    logic [3:0] b2_popcnt;
    logic [3:0] b2_incr_now;
    logic sf_en;
    logic b2_hit;
    logic ival_sf_reg;
    logic burst_sf_reg;
    logic sf_next;
    logic [4:0] prev_reg;
    logic [4:0] cur_def;
    logic [15:0] ival_total;
    logic [15:0] burst_total;
    logic ival_done;
    logic burst_done;
    logic [sfm_pkg::WIN_W-1:0] bwin_len;
    logic [sfm_pkg::WIN_W-1:0] iwin_len;
    logic wr_ctrl;
    logic wr_en;
    logic wr_clr;
    logic rd_evt;

    // Control fields to the rest of the receiver
    assign sf_en = ctrl_reg[sfm_pkg::CTRL_SF_EN];
    assign sd_enable = ctrl_reg[sfm_pkg::CTRL_SD_EN];
    assign descramble_disable = ctrl_reg[sfm_pkg::CTRL_DSCR_DIS];
    assign frame_standard_select = ctrl_reg[sfm_pkg::CTRL_STD_SEL];
    assign rei_err_type = ctrl_reg[sfm_pkg::CTRL_REI_TYPE];
    assign b1_err_type = ctrl_reg[sfm_pkg::CTRL_B1_TYPE];
    assign b2_per_frame = ctrl_reg[sfm_pkg::CTRL_B2_TYPE];

    // Bit count of the errored B2 positions
    always_comb begin
        b2_popcnt = 4'h0;
        for (int i = 0; i < 8; i++) begin
            b2_popcnt = b2_popcnt + {3'h0, b2_err_mask[i]};
        end
    end

    // Per-frame mode counts one, per-bit mode counts every bit
    assign b2_hit = frame_tick && (b2_err_mask != 8'h00);
    assign b2_incr_now = !frame_tick ? 4'h0 :
        (b2_per_frame ? {3'h0, b2_hit} : b2_popcnt);

    // Increment to the B2 counter and REI-L value for the transmitter
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            b2_err_incr <= 4'h0;
            rei_l_value <= 4'h0;
        end else begin
            b2_err_incr <= b2_incr_now;
            if (frame_tick) begin
                rei_l_value <= b2_incr_now;
            end
        end
    end

    // Window lengths: the interval window is eight burst windows
    // A zero burst window acts as one frame, so the interval is then eight
    assign bwin_len = (bwin_reg == 16'h0000) ? 19'h00001 : {3'h0, bwin_reg};
    assign iwin_len = bwin_len << sfm_pkg::INTERVAL_SHIFT;

    // Interval window accumulator
    sfm_win_counter u_ival_win (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(!sf_en),
        .frame_tick(frame_tick),
        .err_incr(b2_incr_now),
        .win_len(iwin_len),
        .total(ival_total),
        .done(ival_done)
    );

    // Burst window accumulator
    sfm_win_counter u_burst_win (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(!sf_en),
        .frame_tick(frame_tick),
        .err_incr(b2_incr_now),
        .win_len(bwin_len),
        .total(burst_total),
        .done(burst_done)
    );

    // Detector states, judged at the end of each window
    always_ff @(posedge sys_clk) begin
        if (reset || !sf_en) begin
            ival_sf_reg <= 1'b0;
            burst_sf_reg <= 1'b0;
        end else begin
            if (ival_done) begin
                if (!ival_sf_reg && ival_total > iset_reg) begin
                    ival_sf_reg <= 1'b1;
                end else if (ival_sf_reg && ival_total <= iclr_reg) begin
                    ival_sf_reg <= 1'b0;
                end
            end
            if (burst_done) begin
                burst_sf_reg <= burst_total > bthr_reg;
            end
        end
    end

    // Overall signal fail
    assign sf_next = ival_sf_reg || burst_sf_reg;
    assign sf_state = sf_next;

    // Defect state view
    assign stat_val = {rdi_state, s1_unstable, k1k2_unstable, sf_state,
        sd_state && sd_enable, lof_state, sef_state, los_state};
    assign cur_def = stat_val[4:0];

    // Events: defect changes and error pulses
    assign evt_set = {prev_reg[4] ^ cur_def[4], prev_reg[3] ^ cur_def[3],
        rei_err_pulse, b2_hit, b1_err_pulse,
        prev_reg[2] ^ cur_def[2], prev_reg[1] ^ cur_def[1],
        prev_reg[0] ^ cur_def[0]};

    // Register port decode
    assign wr_ctrl = wr_stb && addr == sfm_pkg::CTRL_ADDR;
    assign wr_en = wr_stb && addr == sfm_pkg::EVT_EN_ADDR;
    assign wr_clr = wr_stb && addr == sfm_pkg::EVT_CLR_ADDR;
    assign rd_evt = rd_stb && addr == sfm_pkg::EVT_ADDR;
    assign evt_rd_clr = rd_evt ? evt_reg : 8'h00;
    assign evt_wr_clr = wr_clr ? wr_data : 8'h00;
    // New events win over any clear in the same cycle
    assign evt_next = (evt_reg & ~(evt_rd_clr | evt_wr_clr)) | evt_set;

    // Interrupt request, low while an enabled event is latched
    assign int_req_n = ~|(evt_reg & evt_en_reg);

    // Previous defect states and event latch
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prev_reg <= 5'h00;
            evt_reg <= 8'h00;
        end else begin
            prev_reg <= cur_def;
            evt_reg <= evt_next;
        end
    end

    // Writable registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_reg <= sfm_pkg::CTRL_RST;
            evt_en_reg <= sfm_pkg::EVT_EN_RST;
            bwin_reg <= sfm_pkg::BWIN_RST;
            iset_reg <= sfm_pkg::THR_RST;
            iclr_reg <= sfm_pkg::THR_RST;
            bthr_reg <= sfm_pkg::THR_RST;
        end else if (wr_stb) begin
            if (wr_ctrl) begin
                ctrl_reg <= wr_data & sfm_pkg::CTRL_RW_MASK;
            end
            if (wr_en) begin
                evt_en_reg <= wr_data;
            end
            case (addr)
                sfm_pkg::BWIN_HI_ADDR: bwin_reg[15:8] <= wr_data;
                sfm_pkg::BWIN_LO_ADDR: bwin_reg[7:0] <= wr_data;
                sfm_pkg::ISET_HI_ADDR: iset_reg[15:8] <= wr_data;
                sfm_pkg::ISET_LO_ADDR: iset_reg[7:0] <= wr_data;
                sfm_pkg::ICLR_HI_ADDR: iclr_reg[15:8] <= wr_data;
                sfm_pkg::ICLR_LO_ADDR: iclr_reg[7:0] <= wr_data;
                sfm_pkg::BTHR_HI_ADDR: bthr_reg[15:8] <= wr_data;
                sfm_pkg::BTHR_LO_ADDR: bthr_reg[7:0] <= wr_data;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped and write-only addresses read zero
    always_comb begin
        case (addr)
            sfm_pkg::CTRL_ADDR: rd_data_next = ctrl_reg;
            sfm_pkg::STAT_ADDR: rd_data_next = stat_val;
            sfm_pkg::EVT_ADDR: rd_data_next = evt_reg;
            sfm_pkg::EVT_EN_ADDR: rd_data_next = evt_en_reg;
            sfm_pkg::BWIN_HI_ADDR: rd_data_next = bwin_reg[15:8];
            sfm_pkg::BWIN_LO_ADDR: rd_data_next = bwin_reg[7:0];
            sfm_pkg::ISET_HI_ADDR: rd_data_next = iset_reg[15:8];
            sfm_pkg::ISET_LO_ADDR: rd_data_next = iset_reg[7:0];
            sfm_pkg::ICLR_HI_ADDR: rd_data_next = iclr_reg[15:8];
            sfm_pkg::ICLR_LO_ADDR: rd_data_next = iclr_reg[7:0];
            sfm_pkg::BTHR_HI_ADDR: rd_data_next = bthr_reg[15:8];
            sfm_pkg::BTHR_LO_ADDR: rd_data_next = bthr_reg[7:0];
            default: rd_data_next = 8'h00;
        endcase
    end

    // Read data stand one cycle after the strobe only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_stb ? rd_data_next : 8'h00;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_evt_read_clear: assert property (
        rd_evt && evt_set == 8'h00 |=> evt_reg == 8'h00 && rd_data == $past(evt_reg))
        else $error("event latch not cleared by read");

    a_evt_set_wins: assert property (
        (rd_evt || wr_clr) && evt_set != 8'h00 |=> (evt_reg & $past(evt_set)) == $past(evt_set))
        else $error("event lost during clear");

    a_stat_read: assert property (
        rd_stb && addr == sfm_pkg::STAT_ADDR |=> rd_data == $past(stat_val))
        else $error("defect state read wrong");

    a_sd_clear_evt: assert property (
        $fell(stat_val[3]) |=> evt_reg[sfm_pkg::EVT_SD])
        else $error("SD clear gave no event");

    a_ival_declare: assert property (
        sf_en && ival_done && ival_total > iset_reg |=> ival_sf_reg)
        else $error("interval detector missed declare");

    a_burst_same_crit: assert property (
        sf_en && burst_done |=> burst_sf_reg == ($past(burst_total) > $past(bthr_reg)))
        else $error("burst detector criterion wrong");

    a_ival_hold: assert property (
        ival_sf_reg && !ival_done && sf_en |=> ival_sf_reg)
        else $error("interval state changed off window end");

    a_window_ratio: assert property (
        iwin_len == bwin_len * 19'h00008)
        else $error("interval window not eight bursts");

    a_per_frame_one: assert property (
        b2_per_frame && b2_hit |=> b2_err_incr == 4'h1)
        else $error("per-frame count not one");

    a_per_bit_count: assert property (
        !b2_per_frame && frame_tick |=> b2_err_incr == $countones($past(b2_err_mask)))
        else $error("per-bit count wrong");

    a_ctrl_bit7_zero: assert property (
        rd_stb && addr == sfm_pkg::CTRL_ADDR |=> rd_data[7] == 1'b0)
        else $error("control bit 7 not zero");

    a_sf_or: assert property (
        sf_state == (ival_sf_reg || burst_sf_reg))
        else $error("overall SF not OR of detectors");

    a_irq_on_event: assert property (
        (evt_set & evt_en_reg) != 8'h00 |=> !int_req_n)
        else $error("interrupt not raised on event");

    a_sf_disabled: assert property (
        !sf_en |=> !sf_state [*2])
        else $error("SF set while detection disabled");

    a_ctrl_write: assert property (
        wr_ctrl |=> ctrl_reg == ($past(wr_data) & sfm_pkg::CTRL_RW_MASK))
        else $error("control write not taken");

    a_sd_status_low: assert property (
        !sd_state |-> !stat_val[3])
        else $error("SD status high while SD clear");

    a_burst_declare: assert property (
        sf_en && burst_done && burst_total > bthr_reg |=> burst_sf_reg)
        else $error("burst detector missed declare");

    a_b2_event: assert property (
        b2_hit |=> evt_reg[sfm_pkg::EVT_B2])
        else $error("B2 error event not latched");

    a_sf_event: assert property (
        $changed(sf_state) |=> evt_reg[sfm_pkg::EVT_SF])
        else $error("SF change event not latched");

    a_rei_follows: assert property (
        frame_tick |=> rei_l_value == b2_err_incr)
        else $error("REI-L value differs from B2 increment");

    a_per_frame_max: assert property (
        b2_per_frame |-> b2_incr_now <= 4'h1)
        else $error("per-frame increment above one");

    a_ival_clear: assert property (
        sf_en && ival_done && ival_sf_reg && ival_total <= iclr_reg |=> !ival_sf_reg)
        else $error("interval detector missed clear");

    c_ival_declare: cover property (sf_en ##1 $rose(ival_sf_reg));
    c_burst_declare: cover property (sf_en ##1 $rose(burst_sf_reg));
    c_ival_clear: cover property ($fell(ival_sf_reg) && sf_en);
    c_irq_then_read: cover property ($fell(int_req_n) ##[1:20] rd_evt);
    c_per_frame_hit: cover property (b2_per_frame && b2_hit);
endmodule // sfm_monitor

/* pkg/sfm_pkg.sv */
// Constants for the receive line-overhead B2 signal-fail monitor.
// Assumes a byte-wide register port and one frame tick per received frame.
// Overview of operation
// - Eight-bit event latch at 0x110b, clear on read
// - Read-only defect state register at 0x1107
// - Cleared SD shows bit 3 low, raises event
// - Interval detector declares when window count exceeds threshold
// - Burst detector declares when its count exceeds threshold
// - Interval window is eight burst windows long
// - Interval has hysteresis; burst uses one threshold
// - Control bit 1 selects per-bit or per-frame counting
// - Per-bit mode counts each wrong B2 bit
// - Per-frame mode counts one per errored B2 byte
// - Count mode drives SF, REI-L and counter
// - Control register fields; bit 7 reads zero
// - Overall SF is OR of both detectors
// - Latched enabled event pulls interrupt low; any event sets its bit
package sfm_pkg;
    // Register offsets
    localparam logic [15:0] CTRL_ADDR = 16'h1103;
    localparam logic [15:0] STAT_ADDR = 16'h1107;
    localparam logic [15:0] EVT_ADDR = 16'h110b;
    localparam logic [15:0] EVT_EN_ADDR = 16'h1110;
    localparam logic [15:0] EVT_CLR_ADDR = 16'h1111;
    localparam logic [15:0] BWIN_HI_ADDR = 16'h1120;
    localparam logic [15:0] BWIN_LO_ADDR = 16'h1121;
    localparam logic [15:0] ISET_HI_ADDR = 16'h1122;
    localparam logic [15:0] ISET_LO_ADDR = 16'h1123;
    localparam logic [15:0] ICLR_HI_ADDR = 16'h1124;
    localparam logic [15:0] ICLR_LO_ADDR = 16'h1125;
    localparam logic [15:0] BTHR_HI_ADDR = 16'h1126;
    localparam logic [15:0] BTHR_LO_ADDR = 16'h1127;
    // Control field positions
    localparam int CTRL_SF_EN = 6;
    localparam int CTRL_SD_EN = 5;
    localparam int CTRL_DSCR_DIS = 4;
    localparam int CTRL_STD_SEL = 3;
    localparam int CTRL_REI_TYPE = 2;
    localparam int CTRL_B2_TYPE = 1;
    localparam int CTRL_B1_TYPE = 0;
    localparam logic [7:0] CTRL_RW_MASK = 8'h7f;
    // Event latch positions; defect state shares 2..0 for LOF..LOS
    localparam int EVT_SF = 7;
    localparam int EVT_SD = 6;
    localparam int EVT_REI = 5;
    localparam int EVT_B2 = 4;
    localparam int EVT_B1 = 3;
    localparam int EVT_LOF = 2;
    localparam int EVT_SEF = 1;
    localparam int EVT_LOS = 0;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] EVT_EN_RST = 8'hff;
    localparam logic [15:0] BWIN_RST = 16'h0008;
    localparam logic [15:0] THR_RST = 16'hffff;
    // Interval window is burst window shifted by this amount
    localparam int INTERVAL_SHIFT = 3;
    localparam int WIN_W = 19;
endpackage

/* logic/sfm_win_counter.sv */
// Jumping-window B2 error accumulator, one result per window.
// Assumes frame_tick is a one-cycle pulse per received frame.
`timescale 1ns/1ns
module sfm_win_counter (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic frame_tick,
    input wire logic [3:0] err_incr,
    input wire logic [sfm_pkg::WIN_W-1:0] win_len,
    output logic [15:0] total,
    output logic done
);
    logic [sfm_pkg::WIN_W-1:0] frame_cnt_reg;
    logic [15:0] acc_reg;
    logic [16:0] acc_sum;
    logic [15:0] acc_next;
    logic win_end;

    // Saturating sum; a zero length behaves as one frame
    assign acc_sum = {1'b0, acc_reg} + {13'h0000, err_incr};
    assign acc_next = acc_sum[16] ? 16'hffff : acc_sum[15:0];
    assign win_end = (frame_cnt_reg + 19'h00001) >= win_len;

    // Frame counting and result capture
    always_ff @(posedge sys_clk) begin
        if (reset || clear) begin
            frame_cnt_reg <= '0;
            acc_reg <= 16'h0000;
            total <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (frame_tick) begin
                if (win_end) begin
                    frame_cnt_reg <= '0;
                    acc_reg <= 16'h0000;
                    total <= acc_next;
                    done <= 1'b1;
                end else begin
                    frame_cnt_reg <= frame_cnt_reg + 19'h00001;
                    acc_reg <= acc_next;
                end
            end
        end
    end
endmodule // sfm_win_counter

/* verif/sfm_line_model.sv */
// Line-side model: one frame tick per request, with its B2 error mask.
// Assumes the bench raises frame_req for one cycle right after a rising edge.
`timescale 1ns/1ns
module sfm_line_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic frame_req,
    input wire logic [7:0] err_pattern,
    output logic frame_tick,
    output logic [7:0] b2_err_mask
);
    // Tick per request; outside ticks the mask flips to its inverse every cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            frame_tick <= 1'b0;
            b2_err_mask <= 8'h00;
        end else begin
            frame_tick <= frame_req;
            b2_err_mask <= frame_req ? err_pattern : ~b2_err_mask;
        end
    end
endmodule // sfm_line_model

/* verif/sfm_monitor_tb.sv */
// Self-checking bench for the B2 signal-fail monitor: registers, counting,
// defects, interrupt and both detectors. Assumes sfm_pkg offsets and resets.
`timescale 1ns/1ns
module sfm_monitor_tb;
    logic sys_clk, reset, wr_stb, rd_stb, frame_req, frame_tick, int_req_n, sf_state;
    logic [15:0] addr;
    logic [7:0] wr_data, rd_data, err_pattern, b2_err_mask;
    logic los_state, sef_state, lof_state, rdi_state, s1_unstable, k1k2_unstable;
    logic sd_state, b1_err_pulse, rei_err_pulse, sd_enable, descramble_disable;
    logic frame_standard_select, rei_err_type, b1_err_type, b2_per_frame;
    logic [3:0] b2_err_incr, rei_l_value;
    int miscompares = 0;
    int checks_done = 0;

    // Design and line-side partner
    sfm_monitor sfm_monitor_i (.sys_clk, .reset, .addr, .wr_data, .wr_stb, .rd_stb,
        .rd_data, .frame_tick, .b2_err_mask, .los_state, .sef_state, .lof_state,
        .rdi_state, .s1_unstable, .k1k2_unstable, .sd_state, .b1_err_pulse,
        .rei_err_pulse, .int_req_n, .sf_state, .b2_err_incr, .rei_l_value, .sd_enable,
        .descramble_disable, .frame_standard_select, .rei_err_type, .b1_err_type,
        .b2_per_frame);
    sfm_line_model sfm_line_model_i (.sys_clk, .reset, .frame_req, .err_pattern,
        .frame_tick, .b2_err_mask);

    // Verdict and end of run
    task automatic conclude();
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compare one byte-wide result
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Register port: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic wr16(input logic [15:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a + 16'h0001, d[7:0]);
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(negedge sys_clk);
        chk(rd_data, exp);
    endtask

    // One frame; increment looked at in its single cycle, REI-L value as held after it
    task automatic frame(input logic [7:0] m, input logic [3:0] inc);
        @(posedge sys_clk);
        frame_req <= 1'b1;
        err_pattern <= m;
        @(posedge sys_clk);
        frame_req <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({4'h0, b2_err_incr}, {4'h0, inc});
        chk({4'h0, rei_l_value}, {4'h0, inc});
    endtask
    task automatic frames(input int n, input logic [7:0] m, input logic [3:0] inc);
        for (int i = 0; i < n; i++) begin
            frame(m, inc);
        end
    endtask

    // Bounded wait for the overall fail level
    task automatic wait_sf(input logic exp);
        int n;
        n = 0;
        while (sf_state !== exp && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        chk({7'h00, sf_state}, {7'h00, exp});
        if (sf_state !== exp) begin
            conclude();
        end
    endtask
    task automatic hold_sf(input logic exp);
        repeat (4) @(negedge sys_clk);
        chk({7'h00, sf_state}, {7'h00, exp});
    endtask

    // Reset values, read-only places, unused bit and unmapped address
    task automatic t_regs();
        rdchk(sfm_pkg::CTRL_ADDR, 8'h00);
        rdchk(sfm_pkg::STAT_ADDR, 8'h00);
        rdchk(sfm_pkg::EVT_ADDR, 8'h00);
        rdchk(16'h1200, 8'h00);
        wr(sfm_pkg::CTRL_ADDR, 8'hbf);
        rdchk(sfm_pkg::CTRL_ADDR, 8'h3f);
        chk({2'b00, sd_enable, descramble_disable, frame_standard_select, rei_err_type,
            b2_per_frame, b1_err_type}, 8'h3f);
        wr(sfm_pkg::STAT_ADDR, 8'hff);
        rdchk(sfm_pkg::STAT_ADDR, 8'h00);
        wr(sfm_pkg::CTRL_ADDR, 8'h00);
    endtask

    // Per-bit versus per-frame tally, event latch cleared on read
    task automatic t_count();
        frame(8'hff, 4'h8);
        frame(8'h03, 4'h2);
        chk({7'h00, int_req_n}, 8'h00);
        rdchk(sfm_pkg::EVT_ADDR, 8'h10);
        rdchk(sfm_pkg::EVT_ADDR, 8'h00);
        wr(sfm_pkg::CTRL_ADDR, 8'h02);
        @(negedge sys_clk);
        chk({7'h00, b2_per_frame}, 8'h01);
        frame(8'hff, 4'h1);
        frame(8'h80, 4'h1);
        frame(8'h00, 4'h0);
        rdchk(sfm_pkg::EVT_ADDR, 8'h10);
        wr(sfm_pkg::CTRL_ADDR, 8'h00);
    endtask

    // Defect levels into status, SD clearing with its change event
    task automatic set_def(input logic [6:0] v);
        @(posedge sys_clk);
        {rdi_state, s1_unstable, k1k2_unstable, sd_state, lof_state, sef_state,
            los_state} <= v;
    endtask
    task automatic t_defects();
        wr(sfm_pkg::CTRL_ADDR, 8'h20);
        set_def(7'h7f);
        rdchk(sfm_pkg::STAT_ADDR, 8'hef);
        rdchk(sfm_pkg::EVT_ADDR, 8'h47);
        set_def(7'h77);
        rdchk(sfm_pkg::STAT_ADDR, 8'he7);
        rdchk(sfm_pkg::EVT_ADDR, 8'h40);
        set_def(7'h00);
        rdchk(sfm_pkg::EVT_ADDR, 8'h07);
        wr(sfm_pkg::CTRL_ADDR, 8'h00);
    endtask

    // Interrupt raised, masked, cleared by write and by read
    task automatic t_irq();
        wr(sfm_pkg::EVT_EN_ADDR, 8'h00);
        @(posedge sys_clk);
        b1_err_pulse <= 1'b1;
        @(posedge sys_clk);
        b1_err_pulse <= 1'b0;
        @(negedge sys_clk);
        chk({7'h00, int_req_n}, 8'h01);
        wr(sfm_pkg::EVT_EN_ADDR, 8'hff);
        @(negedge sys_clk);
        chk({7'h00, int_req_n}, 8'h00);
        wr(sfm_pkg::EVT_CLR_ADDR, 8'h08);
        @(negedge sys_clk);
        chk({7'h00, int_req_n}, 8'h01);
        @(posedge sys_clk);
        rei_err_pulse <= 1'b1;
        @(posedge sys_clk);
        rei_err_pulse <= 1'b0;
        rdchk(sfm_pkg::EVT_ADDR, 8'h20);
        chk({7'h00, int_req_n}, 8'h01);
    endtask

    // Burst detector: one-frame window, threshold 3, no hysteresis
    task automatic t_burst();
        wr16(sfm_pkg::BWIN_HI_ADDR, 16'h0001);
        wr16(sfm_pkg::BTHR_HI_ADDR, 16'h0003);
        frame(8'h0f, 4'h4);
        hold_sf(1'b0);
        wr(sfm_pkg::CTRL_ADDR, 8'h40);
        frame(8'h0f, 4'h4);
        wait_sf(1'b1);
        rdchk(sfm_pkg::EVT_ADDR, 8'h90);
        frame(8'h07, 4'h3);
        wait_sf(1'b0);
        frame(8'h1f, 4'h5);
        wait_sf(1'b1);
        wr(sfm_pkg::CTRL_ADDR, 8'h00);
        wait_sf(1'b0);
        wr16(sfm_pkg::BTHR_HI_ADDR, 16'hffff);
    endtask

    // Interval detector: eight-frame window, declare above 7, clear at 2 or less
    task automatic t_interval();
        wr16(sfm_pkg::ISET_HI_ADDR, 16'h0007);
        wr16(sfm_pkg::ICLR_HI_ADDR, 16'h0002);
        wr(sfm_pkg::CTRL_ADDR, 8'h40);
        frames(7, 8'h01, 4'h1);
        hold_sf(1'b0);
        frame(8'h01, 4'h1);
        wait_sf(1'b1);
        frames(3, 8'h01, 4'h1);
        frames(5, 8'h00, 4'h0);
        hold_sf(1'b1);
        frames(8, 8'h00, 4'h0);
        wait_sf(1'b0);
        wr(sfm_pkg::CTRL_ADDR, 8'h00);
    endtask

    // Free-running clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        {addr, wr_data, wr_stb, rd_stb, frame_req, err_pattern} = '0;
        {los_state, sef_state, lof_state, rdi_state, s1_unstable, k1k2_unstable} = '0;
        {sd_state, b1_err_pulse, rei_err_pulse} = '0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_count();
        t_defects();
        t_irq();
        t_burst();
        t_interval();
        conclude();
    end
endmodule // sfm_monitor_tb
